// file: inc/dbg_sticky_pkg.sv
// Constants, types and register map for the debug port sticky flag block
package dbg_sticky_pkg;
  // Register map, byte offsets on the bus
  localparam int         ADDR_DEC_W    = 8;
  localparam logic [7:0] ID_OFFSET     = 8'h00;
  localparam logic [7:0] CTRL_OFFSET   = 8'h04;
  localparam logic [7:0] ABORT_OFFSET  = 8'h08;
  // Control/status field positions
  localparam int ORUN_EN_BIT = 0;
  localparam int ORUN_BIT    = 1;
  localparam int MODE_LO     = 2;
  localparam int MODE_HI     = 3;
  localparam int MATCH_BIT   = 4;
  localparam int FAULT_BIT   = 5;
  localparam int PARITY_BIT  = 7;
  localparam int MASK_LO     = 8;
  localparam int MASK_HI     = 11;
  localparam int CNT_LO      = 12;
  localparam int CNT_HI      = 21;
  localparam int MODE_W      = 2;
  localparam int MASK_W      = 4;
  localparam int CNT_W       = 10;
  // Abort register clear bits
  localparam int MATCH_CLR_BIT  = 1;
  localparam int FAULT_CLR_BIT  = 2;
  localparam int PARITY_CLR_BIT = 3;
  localparam int ORUN_CLR_BIT   = 4;
  // Identification register, base value arbitrary
  localparam logic [31:0] ID_BASE     = 32'h0000_1001;
  localparam int          REDUCED_BIT = 16;
  // Transfer modes
  localparam logic [1:0] MODE_NORMAL  = 2'h0;
  localparam logic [1:0] MODE_VERIFY  = 2'h1;
  localparam logic [1:0] MODE_COMPARE = 2'h2;
  // Link acknowledge codes
  localparam logic [2:0] RESP_NONE  = 3'h0;
  localparam logic [2:0] RESP_OK    = 3'h1;
  localparam logic [2:0] RESP_WAIT  = 3'h2;
  localparam logic [2:0] RESP_FAULT = 3'h4;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  // Request presented by the link decoder
  typedef struct packed {
    logic        valid;
    logic        ap;
    logic        write;
    logic        proto_err;
    logic        parity_err;
    logic [3:0]  addr;
    logic [31:0] wdata;
  } link_req_type;
endpackage

// file: src/dbg_sticky_port.sv
// Debug port sticky flags, overrun handling and pushed compare
`timescale 1ns/1ns
module dbg_sticky_port
  import dbg_sticky_pkg::*;
#(
  parameter bit SERIAL_WIRE = 1'b1,
  parameter bit REDUCED     = 1'b0
) (
  // Clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // AHB-Lite slave
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic              hreadyout,
  output logic              hresp,
  output logic [31:0]       hrdata,
  // Link side, sampled from outside the clock domain
  input  wire logic         link_clk,
  input  wire link_req_type link_req,
  output logic              resp_valid,
  output logic [2:0]        resp_code,
  output logic [31:0]       link_rdata,
  // Access port side
  output logic              ap_req,
  output logic              ap_write,
  output logic [3:0]        ap_addr,
  output logic [31:0]       ap_wdata,
  input  wire logic         ap_done,
  input  wire logic         ap_err,
  input  wire logic [31:0]  ap_rdata
);

  typedef enum logic {ST_IDLE, ST_BUSY} state_type;

  state_type         state_ff;
  link_req_type      req_s1_ff;
  link_req_type      req_s2_ff;
  logic              clk_s1_ff;
  logic              clk_s2_ff;
  logic              clk_prev_ff;
  logic              fault_ff;
  logic              match_ff;
  logic              parity_ff;
  logic              orun_ff;
  logic              orun_en_ff;
  logic [MODE_W-1:0] mode_ff;
  logic [MASK_W-1:0] mask_ff;
  logic [CNT_W-1:0]  cnt_ff;
  logic              pushed_ff;
  logic [31:0]       hold_ff;
  logic              wr_pend_ff;
  logic [7:0]        wr_addr_ff;
  logic              ap_req_ff;
  logic              ap_write_ff;
  logic [3:0]        ap_addr_ff;
  logic [31:0]       ap_wdata_ff;
  logic              resp_valid_ff;
  logic [2:0]        resp_code_ff;
  logic [31:0]       link_rdata_ff;
  logic [31:0]       hrdata_ff;
  logic [MASK_W-1:0] lane_eq;

  // Link strobe and request decode
  wire req_fire    = clk_s2_ff & ~clk_prev_ff & req_s2_ff.valid;
  wire is_busy     = (state_ff == ST_BUSY);
  wire any_sticky  = fault_ff | match_ff | parity_ff | orun_ff;
  wire take        = req_fire & req_s2_ff.ap & ~req_s2_ff.proto_err;
  wire overrun_hit = take & is_busy & orun_en_ff;
  wire blocked     = take & ~is_busy & any_sticky;
  wire bad_parity  = req_s2_ff.write & req_s2_ff.parity_err;
  wire parity_hit  = take & ~is_busy & ~any_sticky & bad_parity;
  wire launch      = take & ~is_busy & ~any_sticky & ~bad_parity;
  wire pushed_on   = ~REDUCED & ((mode_ff == MODE_VERIFY) | (mode_ff == MODE_COMPARE));
  wire push_launch = launch & pushed_on & req_s2_ff.write;

  // Response selection towards the link
  wire       respond   = req_fire & ~(SERIAL_WIRE & req_s2_ff.proto_err);
  wire       late_orun = SERIAL_WIRE & orun_ff;
  wire [2:0] busy_code = late_orun ? RESP_FAULT : RESP_WAIT;
  wire [2:0] stop_code = SERIAL_WIRE ? RESP_FAULT : RESP_OK;
  wire [2:0] nxt_resp_code = (take & is_busy) ? busy_code :
                             blocked ? stop_code : RESP_OK;

  // Per byte masked compare of held and returned words
  genvar lane;
  generate
    for (lane = 0; lane < MASK_W; lane = lane + 1) begin : g_lane
      assign lane_eq[lane] = ~mask_ff[lane] |
                             (ap_rdata[lane*8 +: 8] == hold_ff[lane*8 +: 8]);
    end
  endgenerate

  // Access completion outcome
  wire done_ok   = is_busy & ap_done & ~ap_err;
  wire done_err  = is_busy & ap_done & ap_err;
  wire all_eq    = &lane_eq;
  wire want_eq   = (mode_ff == MODE_COMPARE);
  wire match_hit = done_ok & pushed_ff & (all_eq == want_eq);
  wire cnt_zero  = (cnt_ff == {CNT_W{1'b0}});
  wire repeat_go = done_ok & ~match_hit & ~cnt_zero & ~fault_ff & ~match_ff & ~REDUCED;

  // AHB-Lite decode
  wire       addr_phase = hsel & htrans[1] & hready;
  wire       wr_ctrl    = wr_pend_ff & (wr_addr_ff == CTRL_OFFSET);
  wire       wr_abort   = wr_pend_ff & (wr_addr_ff == ABORT_OFFSET);
  wire       clr_match  = wr_abort & hwdata[MATCH_CLR_BIT] & ~REDUCED;
  wire       clr_fault  = wr_abort & hwdata[FAULT_CLR_BIT];
  wire       clr_parity = wr_abort & hwdata[PARITY_CLR_BIT];
  wire       clr_orun   = wr_abort & hwdata[ORUN_CLR_BIT];

  // Sticky flag next values, set wins over clear
  wire nxt_fault  = done_err | (fault_ff & ~clr_fault);
  wire nxt_match  = match_hit | (match_ff & ~clr_match);
  wire nxt_parity = parity_hit | (parity_ff & ~clr_parity);
  wire nxt_orun   = overrun_hit | (orun_ff & ~clr_orun);

  // Counter next value, software write takes priority
  wire [CNT_W-1:0] cnt_dec = cnt_ff - 1'b1;
  wire [CNT_W-1:0] nxt_cnt = REDUCED ? {CNT_W{1'b0}} :
                             wr_ctrl ? hwdata[CNT_HI:CNT_LO] :
                             repeat_go ? cnt_dec : cnt_ff;

  // Control/status read view
  wire [MODE_W-1:0] mode_view  = REDUCED ? {MODE_W{1'b0}} : mode_ff;
  wire [MASK_W-1:0] mask_view  = REDUCED ? {MASK_W{1'b0}} : mask_ff;
  wire              match_view = ~REDUCED & match_ff;
  wire [31:0] ctrl_view = {10'h000, cnt_ff, mask_view, parity_ff, 1'b0, fault_ff,
                           match_view, mode_view, orun_ff, orun_en_ff};
  wire [31:0] id_view   = ID_BASE | ({31'h0000_0000, REDUCED} << REDUCED_BIT);
  wire [7:0]  rd_addr   = haddr[ADDR_DEC_W-1:0];
  wire [31:0] rd_mux    = (rd_addr == ID_OFFSET) ? id_view :
                          (rd_addr == CTRL_OFFSET) ? ctrl_view : WORD_ZERO;

  // Two flop synchronisers for the link pins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_s1_ff   <= '0;
      req_s2_ff   <= '0;
      clk_s1_ff   <= 1'b0;
      clk_s2_ff   <= 1'b0;
      clk_prev_ff <= 1'b0;
    end else begin
      req_s1_ff   <= link_req;
      req_s2_ff   <= req_s1_ff;
      clk_s1_ff   <= link_clk;
      clk_s2_ff   <= clk_s1_ff;
      clk_prev_ff <= clk_s2_ff;
    end
  end

  // Sticky flags and counter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fault_ff  <= 1'b0;
      match_ff  <= 1'b0;
      parity_ff <= 1'b0;
      orun_ff   <= 1'b0;
      cnt_ff    <= {CNT_W{1'b0}};
    end else begin
      fault_ff  <= nxt_fault;
      match_ff  <= nxt_match;
      parity_ff <= nxt_parity;
      orun_ff   <= nxt_orun;
      cnt_ff    <= nxt_cnt;
    end
  end

  // Software controlled fields
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      orun_en_ff <= 1'b0;
      mode_ff    <= MODE_NORMAL;
      mask_ff    <= {MASK_W{1'b0}};
    end else if (wr_ctrl) begin
      orun_en_ff <= hwdata[ORUN_EN_BIT];
      mode_ff    <= REDUCED ? MODE_NORMAL : hwdata[MODE_HI:MODE_LO];
      mask_ff    <= REDUCED ? {MASK_W{1'b0}} : hwdata[MASK_HI:MASK_LO];
    end
  end

  // Access sequencing, one transaction in flight
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= ST_IDLE;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (launch) begin
            state_ff <= ST_BUSY;
          end
        end
        ST_BUSY: begin
          if (ap_done && !repeat_go) begin
            state_ff <= ST_IDLE;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // Access port request and pushed hold register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_req_ff   <= 1'b0;
      ap_write_ff <= 1'b0;
      ap_addr_ff  <= 4'h0;
      ap_wdata_ff <= WORD_ZERO;
      pushed_ff   <= 1'b0;
      hold_ff     <= WORD_ZERO;
    end else begin
      ap_req_ff <= launch | repeat_go;
      if (launch) begin
        ap_write_ff <= req_s2_ff.write & ~pushed_on;
        ap_addr_ff  <= req_s2_ff.addr;
        ap_wdata_ff <= req_s2_ff.wdata;
        pushed_ff   <= push_launch;
        hold_ff     <= req_s2_ff.wdata;
      end
    end
  end

  // Link response
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      resp_valid_ff <= 1'b0;
      resp_code_ff  <= RESP_NONE;
      link_rdata_ff <= WORD_ZERO;
    end else begin
      resp_valid_ff <= respond;
      if (respond) begin
        resp_code_ff <= nxt_resp_code;
      end
      if (done_ok) begin
        link_rdata_ff <= ap_rdata;
      end
    end
  end

  // AHB-Lite address and data phases
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      hrdata_ff  <= WORD_ZERO;
    end else begin
      wr_pend_ff <= addr_phase & hwrite;
      if (addr_phase) begin
        wr_addr_ff <= rd_addr;
      end
      if (addr_phase && !hwrite) begin
        hrdata_ff <= rd_mux;
      end
    end
  end

  // Outputs straight from flops, hreadyout and hresp tied to constants
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign hrdata     = hrdata_ff;
  assign resp_valid = resp_valid_ff;
  assign resp_code  = resp_code_ff;
  assign link_rdata = link_rdata_ff;
  assign ap_req     = ap_req_ff;
  assign ap_write   = ap_write_ff;
  assign ap_addr    = ap_addr_ff;
  assign ap_wdata   = ap_wdata_ff;

  // Checks on the flag and sequencing logic
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence seq_push_launch;
    push_launch;
  endsequence

  sequence seq_read_issued;
    ap_req_ff && !ap_write_ff && pushed_ff;
  endsequence

  AST_STICKY_HOLD: assert property (fault_ff && !clr_fault |=> fault_ff)
    else $error("fault flag dropped without clear");
  AST_DISCARD: assert property (blocked |=> !ap_req_ff && state_ff == ST_IDLE)
    else $error("transaction issued while sticky flag set");
  AST_BLOCK_RESP: assert property (blocked |=> resp_valid_ff && resp_code_ff == stop_code)
    else $error("wrong response while flags set");
  AST_ERR_SET: assert property (done_err |=> fault_ff)
    else $error("access error did not set fault flag");
  AST_ORUN_GATE: assert property ($rose(orun_ff) |-> $past(orun_en_ff))
    else $error("overrun flagged while detection off");
  AST_ORUN_WAIT: assert property (overrun_hit && !orun_ff |=> orun_ff && resp_code_ff == RESP_WAIT)
    else $error("first overrun not answered with wait");
  AST_SW_LATE: assert property (SERIAL_WIRE && take && is_busy && orun_ff |=> resp_code_ff == RESP_FAULT)
    else $error("later overrun response not fault");
  AST_ORUN_KEEP: assert property (overrun_hit && !done_err && !clr_fault |=> fault_ff == $past(fault_ff))
    else $error("overrun changed fault flag");
  AST_PROTO: assert property (SERIAL_WIRE && req_fire && req_s2_ff.proto_err |=> !resp_valid_ff)
    else $error("response given to bad packet");
  AST_PARITY: assert property (parity_hit |=> parity_ff && !ap_req_ff)
    else $error("parity error not recorded");
  AST_REDUCED: assert property (REDUCED |-> ctrl_view[CNT_HI:MASK_LO] == '0 && !ctrl_view[MATCH_BIT] && ctrl_view[MODE_HI:MODE_LO] == '0)
    else $error("reduced fields not zero");
  AST_PUSH_READ: assert property (seq_push_launch |=> seq_read_issued)
    else $error("pushed write not turned into read");
  AST_MATCH_CANCEL: assert property (match_hit |=> match_ff && !ap_req_ff ##1 state_ff == ST_IDLE)
    else $error("repeat not cancelled on match");
  AST_NO_REPEAT: assert property (done_ok && !wr_ctrl && (fault_ff || cnt_zero) |=> !ap_req_ff && cnt_ff == $past(cnt_ff))
    else $error("counter moved while stalled");

endmodule

// file: bench/dbg_link_model.sv
// Debugger model driving link requests and catching the answers
`timescale 1ns/1ns
module dbg_link_model
  import dbg_sticky_pkg::*;
(
  // Clock
  input  wire logic       hclk,
  // Link
  output logic            link_clk,
  output link_req_type    link_req,
  input  wire logic       resp_valid,
  input  wire logic [2:0] resp_code
);
  // Link idle until the first frame
  initial begin
    link_clk = 1'b0;
    link_req = '0;
  end

  // One frame: request held a whole link period, clock only inside it
  task automatic send(input link_req_type r, output logic [2:0] code, output logic got);
    got = 1'b0;
    code = RESP_NONE;
    @(posedge hclk);
    link_req <= r;
    repeat (2) @(posedge hclk);
    #37 link_clk = 1'b1;
    for (int i = 0; i < 5; i++) begin
      @(negedge hclk);
      if (resp_valid === 1'b1) begin
        got = 1'b1;
        code = resp_code;
      end
      if (i == 3) begin
        link_clk = 1'b0;
      end
    end
    @(posedge hclk);
    // Released lines show no stale value
    link_req <= {1'b0, ~r[39:0]};
  endtask
endmodule

// file: bench/dbg_sticky_port_test.sv
// Self-checking bench for the sticky flag and pushed compare block
`timescale 1ns/1ns
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_count++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module dbg_sticky_port_test;
  import dbg_sticky_pkg::*;
  logic         hclk, hresetn, hsel, hwrite, hreadyout, hresp, link_clk;
  logic         resp_valid, ap_req, ap_write, ap_done, ap_err, err_next, got, ap_wr_seen;
  logic [1:0]   htrans;
  logic [2:0]   hsize, resp_code, code;
  logic [3:0]   ap_addr;
  logic [31:0]  haddr, hwdata, hrdata, link_rdata, ap_wdata, ap_rdata, rd, rd_val;
  link_req_type link_req;
  wire          hready = hreadyout;
  int           err_count, num_checks, cyc, ap_reqs, ap_delay, busy, n;

  dbg_sticky_port uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .link_clk(link_clk), .link_req(link_req),
    .resp_valid(resp_valid), .resp_code(resp_code), .link_rdata(link_rdata), .ap_req(ap_req),
    .ap_write(ap_write), .ap_addr(ap_addr), .ap_wdata(ap_wdata), .ap_done(ap_done),
    .ap_err(ap_err), .ap_rdata(ap_rdata));
  dbg_link_model link (.hclk(hclk), .link_clk(link_clk), .link_req(link_req),
    .resp_valid(resp_valid), .resp_code(resp_code));

  // Clock and hang guard
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      close_out();
    end
  end

  // Access port answering after a set delay
  always @(posedge hclk) begin
    ap_done <= 1'b0;
    ap_err <= 1'b0;
    ap_rdata <= ~rd_val;
    if (ap_req === 1'b1) begin
      ap_reqs++;
      ap_wr_seen <= ap_write;
      busy <= ap_delay;
    end else if (busy == 1) begin
      ap_done <= 1'b1;
      ap_err <= err_next;
      ap_rdata <= rd_val;
      busy <= 0;
    end else if (busy > 1) begin
      busy <= busy - 1;
    end
  end

  // Single AHB transfer, rd holds the read data
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    `CHK(hresp, 1'b0)
  endtask

  function automatic link_req_type mk(input logic ap, input logic pe, input logic pr, input logic [31:0] d);
    mk = {1'b1, ap, 1'b1, pr, pe, 4'hc, d};
  endfunction

  // Link frame with its expected answer
  task automatic xfer(input link_req_type r, input logic [2:0] e);
    link.send(r, code, got);
    `CHK(code, e)
  endtask

  task automatic ctrl_bit(input int b, input logic e);
    ahb(1'b0, CTRL_OFFSET, 32'h0);
    `CHK(rd[b], e)
  endtask

  // Map, write-only and unmapped places
  task automatic t_regs;
    ahb(1'b0, ID_OFFSET, 32'h0);
    `CHK(rd, ID_BASE)
    ahb(1'b1, 8'h0c, 32'hffff_ffff);
    ahb(1'b0, 8'h0c, 32'h0);
    `CHK(rd, WORD_ZERO)
    ahb(1'b0, ABORT_OFFSET, 32'h0);
    `CHK(rd, WORD_ZERO)
    ahb(1'b1, CTRL_OFFSET, 32'h003f_ff0d);
    ahb(1'b0, CTRL_OFFSET, 32'h0);
    `CHK(rd, 32'h003f_ff0d)
    ahb(1'b1, CTRL_OFFSET, 32'h0);
  endtask

  // Access error, discard and clear
  task automatic t_fault;
    err_next = 1'b1;
    xfer(mk(1'b1, 1'b0, 1'b0, 32'h1234), RESP_OK);
    repeat (10) @(posedge hclk);
    err_next = 1'b0;
    ctrl_bit(FAULT_BIT, 1'b1);
    n = ap_reqs;
    xfer(mk(1'b1, 1'b0, 1'b0, 32'h1), RESP_FAULT);
    `CHK(ap_reqs, n)
    repeat (50) @(posedge hclk);
    xfer(mk(1'b0, 1'b0, 1'b0, 32'h1), RESP_OK);
    ctrl_bit(FAULT_BIT, 1'b1);
    ahb(1'b1, ABORT_OFFSET, 32'h1 << FAULT_CLR_BIT);
    ctrl_bit(FAULT_BIT, 1'b0);
    xfer(mk(1'b1, 1'b0, 1'b0, 32'h2), RESP_OK);
    repeat (10) @(posedge hclk);
    `CHK(ap_reqs, n + 1)
  endtask

  // Parity flag and protocol error silence
  task automatic t_parity;
    n = ap_reqs;
    xfer(mk(1'b1, 1'b1, 1'b0, 32'h5), RESP_OK);
    ctrl_bit(PARITY_BIT, 1'b1);
    xfer(mk(1'b1, 1'b0, 1'b0, 32'h5), RESP_FAULT);
    ahb(1'b1, ABORT_OFFSET, 32'h1 << PARITY_CLR_BIT);
    ctrl_bit(PARITY_BIT, 1'b0);
    xfer(mk(1'b1, 1'b0, 1'b1, 32'h5), RESP_NONE);
    `CHK(ap_reqs, n)
  endtask

  // Overrun with watch off, then on
  task automatic t_overrun;
    ap_delay = 60;
    xfer(mk(1'b1, 1'b0, 1'b0, 32'h7), RESP_OK);
    xfer(mk(1'b1, 1'b0, 1'b0, 32'h7), RESP_WAIT);
    ctrl_bit(ORUN_BIT, 1'b0);
    repeat (70) @(posedge hclk);
    ahb(1'b1, CTRL_OFFSET, 32'h1);
    n = ap_reqs;
    err_next = 1'b1;
    xfer(mk(1'b1, 1'b0, 1'b0, 32'h7), RESP_OK);
    xfer(mk(1'b1, 1'b0, 1'b0, 32'h7), RESP_WAIT);
    xfer(mk(1'b1, 1'b0, 1'b0, 32'h7), RESP_FAULT);
    ctrl_bit(ORUN_BIT, 1'b1);
    `CHK(rd[FAULT_BIT], 1'b0)
    repeat (70) @(posedge hclk);
    `CHK(ap_reqs, n + 1)
    ctrl_bit(FAULT_BIT, 1'b1);
    err_next = 1'b0;
    // Flag cleared before the watch is dropped
    ahb(1'b1, ABORT_OFFSET, (32'h1 << ORUN_CLR_BIT) | (32'h1 << FAULT_CLR_BIT));
    ahb(1'b1, CTRL_OFFSET, 32'h0);
    ctrl_bit(ORUN_BIT, 1'b0);
    ap_delay = 2;
    xfer(mk(1'b1, 1'b0, 1'b0, 32'h7), RESP_OK);
  endtask

  // Every mode against masks and data, writes only in normal mode
  task automatic t_pushed;
    logic [1:0]  md [8] = '{2'h2, 2'h2, 2'h1, 2'h1, 2'h2, 2'h1, 2'h1, 2'h0};
    logic [3:0]  mask [8] = '{4'hf, 4'hf, 4'hf, 4'hf, 4'h7, 4'h8, 4'h0, 4'hf};
    logic [31:0] rv [8] = '{32'h1122_3344, 32'h1122_3345, 32'h1122_3345, 32'h1122_3344,
                            32'haa22_3344, 32'haa22_3344, 32'hffff_ffff, 32'h0};
    logic [7:0]  exp_hit = 8'h35;
    for (int i = 0; i < 8; i++) begin
      ahb(1'b1, CTRL_OFFSET, {20'h0, mask[i], 4'h0, md[i], 2'b00});
      rd_val = rv[i];
      xfer(mk(1'b1, 1'b0, 1'b0, 32'h1122_3344), RESP_OK);
      repeat (10) @(posedge hclk);
      `CHK(ap_wr_seen, md[i] == MODE_NORMAL)
      ctrl_bit(MATCH_BIT, exp_hit[i]);
      // Match clear written on every pass, taken only on the full variant
      ahb(1'b1, ABORT_OFFSET, 32'h1 << MATCH_CLR_BIT);
    end
  endtask

  // Repeats: full run, stop on match, stop on fault
  task automatic t_counter;
    rd_val = 32'h1122_3344;
    ahb(1'b1, CTRL_OFFSET, 32'h0000_2000);
    n = ap_reqs;
    xfer(mk(1'b1, 1'b0, 1'b0, 32'h1122_3344), RESP_OK);
    repeat (20) @(posedge hclk);
    `CHK(ap_reqs, n + 3)
    `CHK(link_rdata, 32'h1122_3344)
    `CHK(ap_addr, 4'hc)
    `CHK(ap_wdata, 32'h1122_3344)
    ahb(1'b1, CTRL_OFFSET, 32'h0000_3f08);
    xfer(mk(1'b1, 1'b0, 1'b0, 32'h1122_3344), RESP_OK);
    repeat (20) @(posedge hclk);
    `CHK(ap_reqs, n + 4)
    ctrl_bit(MATCH_BIT, 1'b1);
    ahb(1'b1, ABORT_OFFSET, 32'h1 << MATCH_CLR_BIT);
    ahb(1'b1, CTRL_OFFSET, 32'h0000_3000);
    err_next = 1'b1;
    xfer(mk(1'b1, 1'b0, 1'b0, 32'h1), RESP_OK);
    repeat (20) @(posedge hclk);
    err_next = 1'b0;
    `CHK(ap_reqs, n + 5)
    ctrl_bit(FAULT_BIT, 1'b1);
    `CHK(rd[CNT_HI:CNT_LO], 10'h003)
  endtask

  task automatic close_out;
    if (err_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Reset, then the scenarios in turn
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    err_next = 1'b0;
    rd_val = 32'h0;
    ap_delay = 2;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_fault();
    t_parity();
    t_overrun();
    t_pushed();
    t_counter();
    close_out();
  end
endmodule
